// ===== bench/usc_peer.sv
// Far-end serial device model: frame sender and line decoder
`timescale 1ns/1ns
`default_nettype none
module usc_peer import usc_pkg::*; (
    // Clock and shared format
    input  wire logic     sys_clk,
    input  wire usc_cfg_t cfg,
    // Serial line
    input  wire logic     txd,
    output var logic      rxd
);
    logic [9:0] got_q[$];

    initial rxd = 1'b1;

    function automatic int nb();
        return int'(cfg.len) + 5;
    endfunction

    task automatic bits(input int k);
        repeat (k * int'(cfg.divisor)) @(posedge sys_clk);
    endtask

    // Always two stop bits: a single stop bit starves the receiver's realignment
    task automatic send(input logic [7:0] b, input logic bad, input logic brk);
        logic p;
        p = ^(b & 8'((1 << nb()) - 1)) ^ cfg.parity_odd ^ bad;
        @(posedge sys_clk);
        rxd <= 1'b0;
        bits(1);
        for (int i = 0; i < nb(); i++) begin
            rxd <= b[i] & ~brk;
            bits(1);
        end
        if (cfg.parity_en) begin
            rxd <= p & ~brk;
            bits(1);
        end
        if (brk) begin
            bits(1);
        end
        rxd <= 1'b1;
        bits(2);
    endtask

    // Decoded frames are {stop ok, parity ok, data}
    always begin : decode
        logic [7:0] d;
        logic       pok;
        logic       sok;
        @(negedge txd);
        d = 8'h00;
        repeat (int'(cfg.divisor) / 2) @(posedge sys_clk);
        for (int i = 0; i < nb(); i++) begin
            bits(1);
            d[i] = txd;
        end
        pok = 1'b1;
        if (cfg.parity_en) begin
            bits(1);
            pok = (txd === (^d ^ cfg.parity_odd));
        end
        bits(1);
        sok = (txd === 1'b1);
        if (cfg.two_stop) begin
            bits(1);
            sok = sok && (txd === 1'b1);
        end
        got_q.push_back({sok, pok, d});
    end
endmodule
`default_nettype wire

// ===== bench/usc_uart_tb.sv
// Self-checking bench of the serial controller against a queue model
`timescale 1ns/1ns
`default_nettype none
module usc_uart_tb import usc_pkg::*; ;
    logic           sys_clk;
    logic           rst_b;
    usc_cfg_t       cfg;
    logic           tx_valid, tx_ready, rx_valid, rx_ready, rxd, txd;
    logic [7:0]     tx_data, b;
    usc_rx_entry_t  rx_entry;
    logic           cts_b, rts_b, dsr_b, dcd_b, ri_b, modem_ack;
    usc_modem_t     modem_status;
    logic           tx_dma_req, rx_dma_req, irq, baud_locked, fifo_mode, lb_bad;
    usc_irq_t       irq_id;
    logic [15:0]    baud_div;
    logic [31:0]    seed;
    logic [7:0]     exp_q[$];
    int             error_cnt, checks_done, cyc, n;

    usc_uart usc_uart_i (.sys_clk(sys_clk), .rst_b(rst_b), .cfg(cfg), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_entry(rx_entry),
        .rx_ready(rx_ready), .rxd(rxd), .txd(txd), .cts_b(cts_b), .rts_b(rts_b),
        .dsr_b(dsr_b), .dcd_b(dcd_b), .ri_b(ri_b), .modem_ack(modem_ack),
        .modem_status(modem_status), .tx_dma_req(tx_dma_req), .rx_dma_req(rx_dma_req),
        .irq_id(irq_id), .irq(irq), .baud_locked(baud_locked), .baud_div(baud_div),
        .fifo_mode(fifo_mode));
    usc_peer usc_peer_i (.sys_clk(sys_clk), .cfg(cfg), .txd(txd), .rxd(rxd));

    initial sys_clk = 1'b0;
    always #5 sys_clk = ~sys_clk;

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            error_cnt = error_cnt + 1;
            results();
        end
    end

    // Loopback must keep the outside line idle
    always @(negedge sys_clk) begin
        if (cfg.loopback && txd !== 1'b1) lb_bad <= 1'b1;
    end

    task automatic results();
        if (error_cnt == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, e, g);
        end
    endtask

    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction

    // Bits above the configured length never reach the line
    function automatic logic [7:0] msk(input logic [7:0] v);
        return v & 8'((1 << (int'(cfg.len) + 5)) - 1);
    endfunction

    task automatic put_tx(input logic [7:0] v);
        @(negedge sys_clk);
        for (n = 0; n < 2000 && tx_ready !== 1'b1; n++) @(negedge sys_clk);
        tx_valid = 1'b1;
        tx_data = v;
        @(negedge sys_clk);
        tx_valid = 1'b0;
    endtask

    task automatic pop_rx(input logic [10:0] e);
        @(negedge sys_clk);
        for (n = 0; n < 600 && rx_valid !== 1'b1; n++) @(negedge sys_clk);
        chk("rx entry", {5'h00, e}, {5'h00, rx_entry});
        chk("rx dma", 16'h0001, {15'h0, rx_dma_req});
        rx_ready = 1'b1;
        @(negedge sys_clk);
        rx_ready = 1'b0;
    endtask

    task automatic line_chk(input logic [7:0] e);
        logic [9:0] g;
        g = 10'hxxx;
        for (n = 0; n < 600 && usc_peer_i.got_q.size() == 0; n++) @(negedge sys_clk);
        if (usc_peer_i.got_q.size() > 0) g = usc_peer_i.got_q.pop_front();
        chk("line frame", {8'h03, e}, {6'h00, g});
    endtask

    initial begin
        seed = 32'd32091;
        error_cnt = 0;
        checks_done = 0;
        lb_bad = 1'b0;
        cfg = '0;
        cfg.divisor = 16'h000a;
        {tx_valid, tx_data, rx_ready, cts_b, modem_ack} = '0;
        {dsr_b, dcd_b, ri_b} = 3'h7;
        rst_b = 1'b0;
        repeat (6) @(posedge sys_clk);
        chk("reset txd", 16'h0001, {15'h0, txd});
        chk("reset mode", 16'h0000, {15'h0, fifo_mode});
        chk("reset modem", 16'h000f, {12'h0, modem_status});
        chk("reset div", DIV_RST, baud_div);
        @(negedge sys_clk);
        rst_b = 1'b1;
        // Every length, parity on/off, odd/even, both ways
        for (int i = 0; i < 16; i++) begin
            repeat (20) @(negedge sys_clk);
            b = rnd();
            {cfg.parity_odd, cfg.parity_en, cfg.len} = i[3:0];
            cfg.two_stop = seed[9];
            put_tx(b);
            line_chk(msk(b));
            usc_peer_i.send(b, seed[8], 1'b0);
            pop_rx({2'b00, seed[8] & cfg.parity_en, msk(b)});
        end
        cfg.parity_en = 1'b0;
        usc_peer_i.send(8'h00, 1'b0, 1'b1);
        pop_rx(11'h600);
        cfg.loopback = 1'b1;
        put_tx(8'h5a);
        pop_rx({3'b000, msk(8'h5a)});
        chk("loopback idle", 16'h0000, {15'h0, lb_bad});
        cfg.loopback = 1'b0;
        for (int i = 0; i < 4; i++) begin
            b = rnd();
            {dsr_b, dcd_b, ri_b} = b[2:0];
            repeat (2) @(negedge sys_clk);
            chk("modem", {12'h0, b[2:0], cts_b}, {12'h0, modem_status});
        end
        modem_ack = 1'b1;
        @(negedge sys_clk);
        modem_ack = 1'b0;
        // Peer and programmed rate both at 12 clocks per bit for one character, then the programmed rate goes back to 10
        {cfg.autobaud_en, cfg.divisor} = {1'b1, 16'h000c};
        usc_peer_i.send(8'hff, 1'b0, 1'b0);
        cfg.divisor = 16'h000a;
        @(negedge sys_clk);
        chk("baud lock", 16'h0001, {15'h0, baud_locked});
        chk("baud div", 16'h000c, baud_div);
        cfg.autobaud_en = 1'b0;
        // Fill the transmit FIFO while the peer holds clear-to-send off
        {cfg.fifo_en, cfg.flow_en, cts_b} = 3'h7;
        repeat (2) @(negedge sys_clk);
        chk("fifo mode", 16'h0001, {15'h0, fifo_mode});
        for (int i = 0; i < 36; i++) begin
            b = rnd();
            put_tx(b);
            exp_q.push_back(msk(b));
        end
        @(negedge sys_clk);
        chk("tx full", 16'h0000, {15'h0, tx_ready});
        chk("tx dma", 16'h0000, {15'h0, tx_dma_req});
        repeat (200) @(negedge sys_clk);
        chk("paused", 16'h0000, 16'(usc_peer_i.got_q.size()));
        cts_b = 1'b0;
        while (exp_q.size() > 0) line_chk(exp_q.pop_front());
        // One waiting entry on a silent line, then fill the receive FIFO
        b = rnd();
        usc_peer_i.send(b, 1'b0, 1'b0);
        exp_q.push_back(msk(b));
        for (n = 0; n < 600 && irq_id !== IRQ_TIMEOUT; n++) @(negedge sys_clk);
        chk("timeout", 16'h0001, {15'h0, n >= 340 && n <= 420});
        chk("irq", 16'h0001, {15'h0, irq});
        for (int i = 1; i < 36; i++) begin
            b = rnd();
            usc_peer_i.send(b, 1'b0, 1'b0);
            exp_q.push_back(msk(b));
        end
        repeat (4) @(negedge sys_clk);
        chk("rts full", 16'h0001, {15'h0, rts_b});
        while (exp_q.size() > 0) pop_rx({3'b000, exp_q.pop_front()});
        cfg.tx_empty_ie = 1'b1;
        repeat (2) @(negedge sys_clk);
        chk("tx empty irq", 16'(IRQ_TX_EMPTY), 16'(irq_id));
        // Four zero bits in the window, each a pulse of a quarter bit
        {cfg.ir_en, cfg.ir_quarter} = 2'h3;
        put_tx(8'h00);
        n = 0;
        repeat (40) begin
            @(negedge sys_clk);
            n += int'(txd);
        end
        chk("ir pulse", 16'(4 * ((int'(cfg.divisor) * 4) / 16)), 16'(n));
        results();
    end
endmodule
`default_nettype wire

// ===== inc/usc_pkg.sv
// Shared constants, field layouts and state types of the serial controller
package usc_pkg;
    localparam int CLK_HZ      = 100_000_000;
    localparam int MAX_BAUD    = 12_500_000;
    // Fewest clocks per bit that the rate limit allows
    localparam int MIN_DIV     = CLK_HZ / MAX_BAUD;
    localparam int FIFO_DEPTH  = 36;
    localparam int TX_W        = 8;
    localparam int RX_W        = 11;
    // Idle bit times of silence before a timeout is raised
    localparam int TO_BITS     = 40;
    localparam int RX_TRIG     = 18;
    localparam int IR_DEN_SH   = 4;
    localparam logic [2:0]  IR_NUM_SHORT = 3'h3;
    localparam logic [2:0]  IR_NUM_LONG  = 3'h4;
    localparam logic [15:0] DIV_RST      = 16'h0364;
    localparam logic [3:0]  MODEM_RST    = 4'hf;

    typedef struct packed {
        logic [1:0]  len;
        logic        parity_en;
        logic        parity_odd;
        logic        two_stop;
        logic        fifo_en;
        logic        flow_en;
        logic        loopback;
        logic        ir_en;
        logic        ir_quarter;
        logic        autobaud_en;
        logic        tx_empty_ie;
        logic [15:0] divisor;
    } usc_cfg_t;

    // Break in bit 10, framing in bit 9, parity in bit 8
    typedef struct packed {
        logic       brk;
        logic       fe;
        logic       pe;
        logic [7:0] data;
    } usc_rx_entry_t;

    typedef struct packed {
        logic dsr_b;
        logic dcd_b;
        logic ri_b;
        logic cts_b;
    } usc_modem_t;

    typedef enum logic [2:0] {IRQ_NONE, IRQ_LINE, IRQ_RX_DATA, IRQ_TIMEOUT, IRQ_TX_EMPTY,
                              IRQ_MODEM} usc_irq_t;
    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} usc_tx_st_t;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_STOP2} usc_rx_st_t;
endpackage

// ===== verilog/usc_uart.sv
// Serial controller: character FIFOs, framing, flow control, infrared coding
// How it works
// R1: Transmit shifts characters out serially; receive shifts bits back into characters.
// R2: Each outgoing character gets a start bit before and stop bits after.
// R3: Optional parity bit is sent; receiver recomputes it and flags mismatches.
// R4: Five to eight data bits, parity on or off, one or two stop bits.
// R5: Legacy single-entry mode and FIFO mode; reset leaves legacy mode.
// R6: Runs at the device clock; bit rate down to eight clocks per bit.
// R7: Transmit FIFO holds 36 eight-bit characters.
// R8: Receive FIFO holds 36 eleven-bit entries: data plus three error flags.
// R9: Receive entry keeps break in bit 10, framing 9, parity 8.
// R10: Separate DMA requests for transmit and receive.
// R11: Receiver measures a start bit and adopts that bit rate.
// R12: Timeout when received data waits with a silent line; prioritised interrupt code.
// R13: Active-low request output; transmission pauses while clear-to-send is high.
// R14: Modem inputs are sampled and shown as status.
// R15: Infrared mode sends zeros as 3/16 or 4/16 bit pulses and decodes them.
// R16: The far transmitter must send two stop bits per character.
// R17: With two stop bits the receiver realigns to a start edge in the second.
// R18: Loopback feeds the transmitter into the receiver and holds the line idle.
// R19: Line idles high; start bit low one bit; each stop bit high one bit.
`timescale 1ns/1ns
`default_nettype none

module usc_fifo import usc_pkg::*; #(
    parameter int W     = TX_W,
    parameter int DEPTH = FIFO_DEPTH,
    parameter int CW    = $clog2(FIFO_DEPTH + 1)
) (
    // Clock and reset
    input  wire logic          sys_clk,
    input  wire logic          rst_b,
    // Legacy single-entry limit
    input  wire logic          one_deep,
    // Fill side
    input  wire logic          in_valid,
    input  wire logic [W-1:0]  in_data,
    output logic               in_ready,
    // Drain side
    output logic               out_valid,
    output logic [W-1:0]       out_data,
    input  wire logic          out_ready,
    output logic [CW-1:0]      count
);
    localparam int PW = $clog2(DEPTH);
    logic [W-1:0]  mem_q [DEPTH];
    logic [PW-1:0] wr_q;
    logic [PW-1:0] rd_q;
    logic [CW-1:0] cnt_q;
    logic          push;
    logic          pop;

    function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
        return (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction

    assign in_ready  = cnt_q < (one_deep ? CW'(1) : CW'(DEPTH)); // R5
    assign out_valid = cnt_q != '0;
    assign out_data  = mem_q[rd_q];
    assign count     = cnt_q;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) wr_q <= next_ptr(wr_q);
            if (pop) rd_q <= next_ptr(rd_q);
            cnt_q <= cnt_q + CW'(push) - CW'(pop);
        end
    end
endmodule

module usc_uart import usc_pkg::*; #(
    parameter int DEPTH = FIFO_DEPTH,
    parameter int CW    = $clog2(FIFO_DEPTH + 1)
) (
    // Clock and reset
    input  wire logic          sys_clk,
    input  wire logic          rst_b,
    // Configuration
    input  wire usc_cfg_t      cfg,
    // Characters to send
    input  wire logic          tx_valid,
    input  wire logic [7:0]    tx_data,
    output logic               tx_ready,
    // Received entries
    output logic               rx_valid,
    output usc_rx_entry_t      rx_entry,
    input  wire logic          rx_ready,
    // Serial line and flow control
    input  wire logic          rxd,
    output logic               txd,
    input  wire logic          cts_b,
    output logic               rts_b,
    // Modem inputs
    input  wire logic          dsr_b,
    input  wire logic          dcd_b,
    input  wire logic          ri_b,
    input  wire logic          modem_ack,
    output usc_modem_t         modem_status,
    // Service requests and status
    output logic               tx_dma_req,
    output logic               rx_dma_req,
    output usc_irq_t           irq_id,
    output logic               irq,
    output logic               baud_locked,
    output logic [15:0]        baud_div,
    output logic               fifo_mode
);
    usc_tx_st_t    tx_st_q;
    usc_rx_st_t    rx_st_q;
    usc_rx_entry_t rx_word_q;
    usc_modem_t    modem_q;
    usc_irq_t      irq_d;
    usc_irq_t      irq_q;
    logic          fifo_mode_q, txd_q, rts_b_q, mchg_q;
    logic [15:0]   div_q, tx_cnt_q, rx_cnt_q, ir_cnt_q, ab_cnt_q, ab_div_q, ir_len;
    logic [7:0]    tx_sh_q, rx_sh_q, tx_fd, rx_data;
    logic [2:0]    tx_idx_q, rx_idx_q, last_idx;
    logic          tx_par_q, tx_stop2_q, tx_fv, tx_go, tx_tick, tx_line, ir_pulse;
    logic          rx_line_q, rx_prev_q, rx_fall, rx_tick, rx_pe_q, rx_zero_q, rx_push_q;
    logic          rx_room, ab_done_q, ab_meas_q, ab_hunt, rx_timeout, line_err;
    logic [CW-1:0] tx_cnt, rx_cnt;
    logic [19:0]   ir_prod;
    logic [23:0]   to_cnt_q, to_limit;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    function automatic logic [7:0] len_mask(input logic [1:0] l);
        return 8'hff >> (2'h3 - l);
    endfunction

    function automatic logic [15:0] half_of(input logic [15:0] d);
        return (d >> 1) - 16'h1;
    endfunction

    assign last_idx = 3'h4 + {1'b0, cfg.len}; // R4

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            fifo_mode_q <= 1'b0; // R5
            div_q       <= DIV_RST;
        end else begin
            fifo_mode_q <= cfg.fifo_en;
            div_q       <= ab_done_q ? ab_div_q : cfg.divisor; // R11
        end
    end

    usc_fifo #(.W(TX_W), .DEPTH(DEPTH), .CW(CW)) u_tx_fifo ( // R7
        .sys_clk   (sys_clk),
        .rst_b     (rst_b),
        .one_deep  (!fifo_mode_q),
        .in_valid  (tx_valid),
        .in_data   (tx_data),
        .in_ready  (tx_ready),
        .out_valid (tx_fv),
        .out_data  (tx_fd),
        .out_ready (tx_go),
        .count     (tx_cnt)
    );

    usc_fifo #(.W(RX_W), .DEPTH(DEPTH), .CW(CW)) u_rx_fifo ( // R8
        .sys_clk   (sys_clk),
        .rst_b     (rst_b),
        .one_deep  (!fifo_mode_q),
        .in_valid  (rx_push_q),
        .in_data   (rx_word_q),
        .in_ready  (rx_room),
        .out_valid (rx_valid),
        .out_data  (rx_entry),
        .out_ready (rx_ready),
        .count     (rx_cnt)
    );

    // Transmitter
    assign tx_go   = tx_st_q == TX_IDLE && tx_fv && (!cfg.flow_en || !cts_b); // R13
    assign tx_tick = tx_cnt_q == '0;

    always_comb begin
        unique case (tx_st_q)
            TX_START:         tx_line = 1'b0; // R19
            TX_DATA:          tx_line = tx_sh_q[0];
            TX_PAR:           tx_line = tx_par_q;
            TX_IDLE, TX_STOP: tx_line = 1'b1;
            default:          tx_line = 1'b1;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_st_q    <= TX_IDLE;
            tx_cnt_q   <= '0;
            tx_sh_q    <= '0;
            tx_par_q   <= 1'b0;
            tx_idx_q   <= '0;
            tx_stop2_q <= 1'b0;
        end else begin
            tx_cnt_q <= (tx_tick || tx_go) ? div_q - 16'h1 : tx_cnt_q - 16'h1;
            unique case (tx_st_q)
                TX_IDLE: if (tx_go) begin
                    tx_sh_q  <= tx_fd;
                    tx_par_q <= ^(tx_fd & len_mask(cfg.len)) ^ cfg.parity_odd; // R3
                    tx_st_q  <= TX_START; // R2
                end
                TX_START: if (tx_tick) begin
                    tx_st_q  <= TX_DATA;
                    tx_idx_q <= '0;
                end
                TX_DATA: if (tx_tick) begin
                    tx_sh_q    <= tx_sh_q >> 1; // R1
                    tx_idx_q   <= tx_idx_q + 3'h1;
                    tx_stop2_q <= 1'b0;
                    if (tx_idx_q == last_idx) tx_st_q <= cfg.parity_en ? TX_PAR : TX_STOP;
                end
                TX_PAR: if (tx_tick) tx_st_q <= TX_STOP;
                TX_STOP: if (tx_tick) begin
                    if (cfg.two_stop && !tx_stop2_q) tx_stop2_q <= 1'b1; // R4
                    else tx_st_q <= TX_IDLE;
                end
            endcase
        end
    end

    // Pulse width follows the live divisor, so it tracks a detected rate too
    assign ir_prod  = {4'h0, div_q} * {17'h0, cfg.ir_quarter ? IR_NUM_LONG : IR_NUM_SHORT};
    assign ir_len   = 16'(ir_prod >> IR_DEN_SH);
    assign ir_pulse = !tx_line && (div_q - 16'h1 - tx_cnt_q) < ir_len; // R15

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) txd_q <= 1'b1;
        else txd_q <= cfg.loopback ? 1'b1 : (cfg.ir_en ? ir_pulse : tx_line); // R18
    end

    // Receive line: infrared pulses are stretched to a full low bit
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ir_cnt_q  <= '0;
            rx_line_q <= 1'b1;
            rx_prev_q <= 1'b1;
        end else begin
            if (rxd) ir_cnt_q <= div_q - 16'h1;
            else if (ir_cnt_q != '0) ir_cnt_q <= ir_cnt_q - 16'h1;
            rx_line_q <= cfg.loopback ? tx_line // R18
                       : (cfg.ir_en ? !(rxd || ir_cnt_q != '0) : rxd); // R15
            rx_prev_q <= rx_line_q;
        end
    end

    assign rx_fall = rx_prev_q && !rx_line_q;
    assign rx_tick = rx_cnt_q == '0;
    assign rx_data = rx_sh_q >> (2'h3 - cfg.len);

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_st_q   <= RX_IDLE;
            rx_cnt_q  <= '0;
            rx_sh_q   <= '0;
            rx_idx_q  <= '0;
            rx_pe_q   <= 1'b0;
            rx_zero_q <= 1'b0;
            rx_push_q <= 1'b0;
            rx_word_q <= '0;
        end else begin
            rx_push_q <= 1'b0;
            rx_cnt_q  <= rx_tick ? div_q - 16'h1 : rx_cnt_q - 16'h1;
            unique case (rx_st_q)
                RX_IDLE: if (rx_fall && !ab_hunt) begin
                    rx_st_q   <= RX_START;
                    rx_cnt_q  <= half_of(div_q);
                    rx_zero_q <= 1'b1;
                    rx_pe_q   <= 1'b0;
                end
                // A start that is high again at mid-bit was a glitch
                RX_START: if (rx_tick) begin
                    rx_st_q  <= rx_line_q ? RX_IDLE : RX_DATA;
                    rx_idx_q <= '0;
                end
                RX_DATA: if (rx_tick) begin
                    rx_sh_q   <= {rx_line_q, rx_sh_q[7:1]}; // R1
                    rx_zero_q <= rx_zero_q && !rx_line_q;
                    rx_idx_q  <= rx_idx_q + 3'h1;
                    if (rx_idx_q == last_idx) rx_st_q <= cfg.parity_en ? RX_PAR : RX_STOP;
                end
                RX_PAR: if (rx_tick) begin
                    rx_pe_q   <= rx_line_q != (^rx_data ^ cfg.parity_odd); // R3
                    rx_zero_q <= rx_zero_q && !rx_line_q;
                    rx_st_q   <= RX_STOP;
                end
                RX_STOP: if (rx_tick) begin
                    rx_word_q <= '{brk: rx_zero_q && !rx_line_q, fe: !rx_line_q,
                                   pe: rx_pe_q, data: rx_data}; // R9
                    rx_push_q <= 1'b1;
                    rx_st_q   <= cfg.two_stop ? RX_STOP2 : RX_IDLE;
                end
                // Realignment is held off too while the rate is still being measured
                RX_STOP2: if (rx_fall && !ab_hunt) begin
                    rx_st_q   <= RX_START; // R17
                    rx_cnt_q  <= half_of(div_q);
                    rx_zero_q <= 1'b1;
                    rx_pe_q   <= 1'b0;
                end else if (rx_tick) begin
                    rx_st_q <= RX_IDLE;
                end
            endcase
        end
    end

    // Rate detection times the first start bit; that character must send bit 0 high
    assign ab_hunt = cfg.autobaud_en && !ab_done_q;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ab_done_q <= 1'b0;
            ab_meas_q <= 1'b0;
            ab_cnt_q  <= '0;
            ab_div_q  <= '0;
        end else if (!cfg.autobaud_en) begin
            ab_done_q <= 1'b0;
            ab_meas_q <= 1'b0;
        end else if (ab_hunt) begin
            if (!ab_meas_q && rx_fall) begin
                ab_meas_q <= 1'b1;
                ab_cnt_q  <= 16'h1;
            end else if (ab_meas_q && rx_line_q) begin
                ab_meas_q <= 1'b0;
                if (ab_cnt_q >= 16'(MIN_DIV)) begin // R11
                    ab_div_q  <= ab_cnt_q;
                    ab_done_q <= 1'b1;
                end
            end else if (ab_meas_q && ab_cnt_q != 16'hffff) begin
                ab_cnt_q <= ab_cnt_q + 16'h1;
            end
        end
    end

    // Receive timeout counts clocks of silence while data waits
    assign to_limit   = 24'(div_q * TO_BITS);
    assign rx_timeout = rx_valid && to_cnt_q >= to_limit; // R12

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) to_cnt_q <= '0;
        else if (!rx_valid || rx_push_q || rx_ready || rx_st_q != RX_IDLE) to_cnt_q <= '0;
        else if (to_cnt_q < to_limit) to_cnt_q <= to_cnt_q + 24'h1;
    end

    // Modem inputs, change flag where a new change beats the acknowledge
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            modem_q <= MODEM_RST;
            mchg_q  <= 1'b0;
        end else begin
            modem_q <= '{dsr_b: dsr_b, dcd_b: dcd_b, ri_b: ri_b, cts_b: cts_b}; // R14
            mchg_q  <= (modem_q != {dsr_b, dcd_b, ri_b, cts_b}) || (mchg_q && !modem_ack);
        end
    end

    assign line_err = rx_valid && (rx_entry.brk || rx_entry.fe || rx_entry.pe);

    always_comb begin
        if (line_err) irq_d = IRQ_LINE; // R12
        else if (rx_valid && (!fifo_mode_q || rx_cnt >= CW'(RX_TRIG))) irq_d = IRQ_RX_DATA;
        else if (rx_timeout) irq_d = IRQ_TIMEOUT;
        else if (cfg.tx_empty_ie && !tx_fv && tx_st_q == TX_IDLE) irq_d = IRQ_TX_EMPTY;
        else if (mchg_q) irq_d = IRQ_MODEM;
        else irq_d = IRQ_NONE;
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_q   <= IRQ_NONE;
            rts_b_q <= 1'b1;
        end else begin
            irq_q   <= irq_d;
            rts_b_q <= cfg.flow_en && !rx_room; // R13
        end
    end

    assign txd          = txd_q;
    assign rts_b        = rts_b_q;
    assign modem_status = modem_q;
    assign irq_id       = irq_q;
    assign irq          = irq_q != IRQ_NONE;
    assign tx_dma_req   = tx_ready; // R10
    assign rx_dma_req   = rx_valid; // R10
    assign baud_locked  = ab_done_q;
    assign baud_div     = div_q; // R6
    assign fifo_mode    = fifo_mode_q;

    start_bit_low_a: assert property ( // R2
        (tx_st_q == TX_START && !cfg.loopback && !cfg.ir_en) |=> !txd_q)
        else $error("start bit not driven low");
    stop_bit_high_a: assert property ( // R19
        (tx_st_q == TX_STOP && !cfg.loopback && !cfg.ir_en) |=> txd_q)
        else $error("stop bit not driven high");
    cts_pause_a: assert property ( // R13
        (tx_st_q == TX_IDLE && cfg.flow_en && cts_b) |=> tx_st_q == TX_IDLE)
        else $error("character started while clear-to-send high");
    loop_idle_a: assert property (cfg.loopback |=> txd_q) // R18
        else $error("line not idle in loopback");
    legacy_depth_a: assert property ((!fifo_mode_q && tx_cnt != '0) |-> !tx_ready) // R5
        else $error("legacy mode accepted a second character");
    fifo_bound_a: assert property (tx_cnt <= CW'(DEPTH) && rx_cnt <= CW'(DEPTH)) // R7
        else $error("fifo count beyond depth");
    break_frame_a: assert property ( // R9
        (rx_push_q && rx_word_q.brk) |-> (rx_word_q.fe && rx_word_q.data == 8'h00))
        else $error("break entry without framing error or zero data");
    parity_off_a: assert property ( // R3
        (rx_st_q == RX_STOP && rx_tick && !cfg.parity_en) |=> !rx_word_q.pe)
        else $error("parity error with parity disabled");
    timeout_irq_a: assert property (rx_timeout |=> irq) // R12
        else $error("timeout without interrupt");
    ir_one_dark_a: assert property ((cfg.ir_en && !cfg.loopback && tx_line) |=> !txd_q) // R15
        else $error("infrared pulse for a one bit");
    baud_adopt_a: assert property ($rose(ab_done_q) |=> div_q == ab_div_q) // R11
        else $error("detected rate not adopted");
endmodule

`default_nettype wire
